// ---- logic/wdg_top.sv ----
`timescale 1ns/1ps
`include "wdg_defs.svh"

// ==================================================
// Guard timer with reset cause flags and low-voltage reset logic
module wdg_top #(
   parameter int LV_FILTER_CYC =
      (`LV_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // Clock, reset, freeze
   input  logic                      clk,
   input  logic                      sys_rst,
   input  logic                      clk_en,
   // Register port
   input  logic [`ADDR_W-1:0]        reg_addr,
   input  wdg_pkg::wdg_byte_t        reg_wdata,
   input  logic                      reg_wr,
   input  logic                      reg_rd,
   output wdg_pkg::wdg_byte_t        rd_data_r,
   // Core events
   input  logic                      clear_guard_instruction,
   input  logic                      halt_exec,
   input  logic                      pd_mode,
   // Pins from other domains
   input  logic                      slow_internal_osc,
   input  logic                      lowvolt_det,
   // Reset and status outputs
   output logic                      dev_rst_r,
   output logic                      pcsp_rst_r,
   output logic                      pc_clear_r,
   output logic                      port_high_r,
   output logic                      expiry_flag_r,
   output logic                      powerdown_flag_r
);

   // ==================================================
   // Declarations
   wdg_pkg::wdg_byte_t     guard_control_r;
   wdg_pkg::wdg_byte_t     lowvolt_level_register_r;
   logic [`FLG_W-1:0]      reset_cause_flags_r;
   logic [`FLG_W-1:0]      flags_nxt;
   logic [`CNT_W-1:0]      cnt_r;
   logic [`LV_CNT_W-1:0]   lv_cnt_r;
   wdg_pkg::wdg_cause_t    cause_r;
   wdg_pkg::wdg_byte_t     rd_nxt;
   logic [`SYNC_W-1:0]     pins_raw;
   logic [`SYNC_W-1:0]     pins_s;
   logic                   osc_q_r;
   logic                   tick;
   logic [4:0]             guard_enable_key;
   logic [2:0]             expiry_select;
   logic                   guard_on;
   logic                   exp_ev;
   logic                   gkey_fire;
   logic                   lvkey_fire;
   logic                   gkey_ev;
   logic                   lvkey_ev;
   logic                   lv_armed;
   logic                   lv_low_s;
   logic                   lv_ev;
   logic                   full_ev;
   logic                   part_ev;
   logic                   wr_guard;
   logic                   wr_lvsel;
   logic                   wr_flags;

   // ==================================================
   // Decoding helpers
   // Enable key is legal only in its two codes
   function automatic logic key_ok(input logic [4:0] k);
      return (k == `KEY_ON) || (k == `KEY_OFF);
   endfunction : key_ok

   // Level select is legal only in its six codes
   function automatic logic lv_ok(input wdg_pkg::wdg_byte_t v);
      logic ok;
      ok = 1'h0;
      unique case (v)
         `LV_1V7, `LV_1V9, `LV_2V55, `LV_3V15, `LV_3V8, `LV_OFF: ok = 1'h1;
         default: ok = 1'h0;
      endcase
      return ok;
   endfunction : lv_ok

   // Last count before expiry for each select code
   function automatic logic [`CNT_W-1:0] last_count(input logic [2:0] sel);
      logic [`CNT_W-1:0] m;
      m = `LAST_S0;
      unique case (sel)
         3'h0: m = `LAST_S0;
         3'h1: m = `LAST_S1;
         3'h2: m = `LAST_S2;
         3'h3: m = `LAST_S3;
         3'h4: m = `LAST_S4;
         3'h5: m = `LAST_S5;
         3'h6: m = `LAST_S6;
         3'h7: m = `LAST_S7;
      endcase
      return m;
   endfunction : last_count

   // ==================================================
   // Pin synchronisers
   assign pins_raw = {lowvolt_det, slow_internal_osc};

   // Both asynchronous pins take the same three-stage path
   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
         wdg_sync3 u_sync (
            .clk     (clk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .pin     (pins_raw[gi]),
            .level_r (pins_s[gi])
         );
      end
   endgenerate

   assign lv_low_s = pins_s[1];

   // Slow clock edge, seen as a rising edge of the clean level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         osc_q_r <= 1'h0;
      end else if (clk_en) begin
         osc_q_r <= pins_s[0];
      end
   end

   assign tick = clk_en & pins_s[0] & ~osc_q_r; // R01

   // ==================================================
   // Event decode
   assign guard_enable_key = guard_control_r[`KEY_MSB:`KEY_LSB];
   assign expiry_select    = guard_control_r[`SEL_MSB:0];
   assign guard_on         = (guard_enable_key == `KEY_ON); // R03

   // Expiry on the slow edge that would pass the selected point
   assign exp_ev = tick & guard_on & (cnt_r == last_count(expiry_select)); // R02 R07

   assign gkey_ev  = clk_en & gkey_fire;
   assign lvkey_ev = clk_en & lvkey_fire;

   // Low-voltage watch is off when disabled or in power-down
   assign lv_armed = lv_ok(lowvolt_level_register_r) & ~pd_mode   // R15
                   & (lowvolt_level_register_r != `LV_OFF);
   assign lv_ev = clk_en & lv_armed & lv_low_s
                & (lv_cnt_r == `LV_CNT_W'(LV_FILTER_CYC)); // R12

   // Any full cause wins over a power-down expiry
   assign full_ev = gkey_ev | lvkey_ev | lv_ev | (exp_ev & ~pd_mode); // R08
   assign part_ev = exp_ev & pd_mode & ~full_ev; // R09

   assign wr_guard = reg_wr & (reg_addr == `OFF_GUARD);
   assign wr_lvsel = reg_wr & (reg_addr == `OFF_LVSEL);
   assign wr_flags = reg_wr & (reg_addr == `OFF_FLAGS);

   // ==================================================
   // Key fault delays
   wdg_slow_delay u_gkey_dly (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .arm     (~key_ok(guard_enable_key)), // R04
      .tick    (tick),
      .fire_r  (gkey_fire)
   );

   wdg_slow_delay u_lvkey_dly (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .arm     (~lv_ok(lowvolt_level_register_r)), // R13
      .tick    (tick),
      .fire_r  (lvkey_fire)
   );

   // ==================================================
   // Guard control register
   // A full reset returns the key to running, even over a same-cycle write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         guard_control_r <= `GUARD_POR; // R05
      end else if (clk_en) begin
         if (full_ev) begin
            guard_control_r <= `GUARD_POR;
         end else if (wr_guard) begin
            guard_control_r <= reg_wdata;
         end
      end
   end

   // ==================================================
   // Level select register
   // Only the level key fault restores it; a low-voltage reset keeps it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lowvolt_level_register_r <= `LVSEL_POR; // R14
      end else if (clk_en) begin
         if (lvkey_ev) begin
            lowvolt_level_register_r <= `LVSEL_POR; // R19
         end else if (wr_lvsel) begin
            lowvolt_level_register_r <= reg_wdata;
         end
      end
   end

   // ==================================================
   // Guard counter
   // Clears restart from zero; a stopped timer holds its count
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else if (clk_en) begin
         if (clear_guard_instruction | halt_exec | full_ev | exp_ev) begin // R10
            cnt_r <= '0; // R20
         end else if (tick & guard_on) begin
            cnt_r <= cnt_r + `CNT_W'(1); // R20
         end
      end
   end

   // ==================================================
   // Low-voltage filter
   // Counts system clocks of continuous low supply, so short dips vanish
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lv_cnt_r <= '0;
      end else if (clk_en) begin
         if (!(lv_armed & lv_low_s) | lv_ev) begin
            lv_cnt_r <= '0; // R12
         end else begin
            lv_cnt_r <= lv_cnt_r + `LV_CNT_W'(1);
         end
      end
   end

   // ==================================================
   // Reset cause flags
   // Software writes zero to clear; a hardware set in the same cycle wins
   always_comb begin
      flags_nxt = reset_cause_flags_r;
      if (wr_flags) begin
         flags_nxt = flags_nxt & reg_wdata[`FLG_W-1:0]; // R06 R18
      end
      if (gkey_ev) begin
         flags_nxt[`FLG_GKEY] = 1'h1; // R04
      end
      if (lvkey_ev) begin
         flags_nxt[`FLG_LVKEY] = 1'h1; // R13
      end
      if (lv_ev) begin
         flags_nxt[`FLG_LOWV] = 1'h1; // R18
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reset_cause_flags_r <= '0;
      end else if (clk_en) begin
         reset_cause_flags_r <= flags_nxt;
      end
   end

   // ==================================================
   // Expiry and power-down status
   // Clear instruction drops both, halt marks power-down, expiry sets last
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         expiry_flag_r    <= 1'h0;
         powerdown_flag_r <= 1'h0;
      end else if (clk_en) begin
         if (clear_guard_instruction) begin
            expiry_flag_r    <= 1'h0;
            powerdown_flag_r <= 1'h0;
         end
         if (halt_exec) begin
            expiry_flag_r    <= 1'h0;
            powerdown_flag_r <= 1'h1;
         end
         if (exp_ev) begin
            expiry_flag_r <= 1'h1; // R08
            if (pd_mode) begin
               powerdown_flag_r <= 1'h1; // R09
            end
         end
      end
   end

   // ==================================================
   // Last cause, a read-only aid for software after a restart
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cause_r <= wdg_pkg::CAUSE_NONE;
      end else if (clk_en) begin
         if (gkey_ev) begin
            cause_r <= wdg_pkg::CAUSE_GKEY;
         end else if (lvkey_ev) begin
            cause_r <= wdg_pkg::CAUSE_LVKEY;
         end else if (lv_ev) begin
            cause_r <= wdg_pkg::CAUSE_LOWV;
         end else if (exp_ev) begin
            cause_r <= wdg_pkg::CAUSE_EXPIRY;
         end
      end
   end

   // ==================================================
   // Reset outputs
   // Power-on holds program counter clear and ports high until release
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dev_rst_r   <= 1'h0;
         pcsp_rst_r  <= 1'h0;
         pc_clear_r  <= 1'h1; // R16
         port_high_r <= 1'h1; // R17
      end else if (clk_en) begin
         dev_rst_r   <= full_ev; // R07
         pcsp_rst_r  <= part_ev; // R09
         pc_clear_r  <= full_ev | part_ev;
         port_high_r <= full_ev;
      end
   end

   // ==================================================
   // Register read
   always_comb begin
      rd_nxt = '0;
      unique case (reg_addr)
         `OFF_GUARD:  rd_nxt = guard_control_r;
         `OFF_LVSEL:  rd_nxt = lowvolt_level_register_r;
         `OFF_FLAGS:  rd_nxt[`FLG_W-1:0] = reset_cause_flags_r; // R11
         `OFF_STATUS: begin
            rd_nxt[`ST_EXP] = expiry_flag_r;
            rd_nxt[`ST_PD]  = powerdown_flag_r;
            rd_nxt[`ST_CAUSE_MSB:`ST_CAUSE_LSB] = cause_r;
         end
         default:     rd_nxt = '0;
      endcase
   end

   // Data stand for one cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data_r <= '0;
      end else if (clk_en) begin
         rd_data_r <= reg_rd ? rd_nxt : '0;
      end
   end

   // ==================================================
   // Checks
   sequence s_key_fire;
      gkey_fire && clk_en;
   endsequence

   sequence s_key_answer;
      dev_rst_r && reset_cause_flags_r[`FLG_GKEY] && guard_control_r == `GUARD_POR;
   endsequence

   sequence s_pd_expiry;
      exp_ev && pd_mode && !gkey_fire && !lvkey_fire && !lv_ev;
   endsequence

   sequence s_part_answer;
      pcsp_rst_r && !dev_rst_r && expiry_flag_r && powerdown_flag_r;
   endsequence

   AST_POR_VALUES: assert property (@(posedge clk) // R05 R14
      sys_rst |=> guard_control_r == `GUARD_POR && lowvolt_level_register_r == `LVSEL_POR
                  && pc_clear_r && port_high_r)
      else $error("power-on values wrong");

   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R11
      reg_rd && clk_en && reg_addr == `OFF_FLAGS |=> rd_data_r[7:`FLG_W] == '0)
      else $error("reserved flag bits not zero");

   AST_KEY_RESET: assert property (@(posedge clk) disable iff (sys_rst) // R04
      s_key_fire |=> s_key_answer)
      else $error("key fault gave no reset");

   AST_KEY_FLAG_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R06
      reset_cause_flags_r[`FLG_GKEY] && !wr_flags |=> reset_cause_flags_r[`FLG_GKEY])
      else $error("key flag cleared by hardware");

   AST_EXP_NORMAL: assert property (@(posedge clk) disable iff (sys_rst) // R08
      exp_ev && !pd_mode |=> dev_rst_r && expiry_flag_r && cnt_r == '0)
      else $error("normal expiry not a full reset");

   AST_EXP_PD: assert property (@(posedge clk) disable iff (sys_rst) // R09
      s_pd_expiry |=> s_part_answer)
      else $error("power-down expiry wrong");

   AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R10
      clk_en && (clear_guard_instruction || halt_exec) |=> cnt_r == '0)
      else $error("counter not cleared");

   AST_LV_PD_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R15
      pd_mode |-> !lv_ev ##1 (lv_cnt_r == '0 || !$past(clk_en)))
      else $error("low-voltage reset in power-down");

   AST_LV_RESET: assert property (@(posedge clk) disable iff (sys_rst) // R12
      lv_ev |=> dev_rst_r && reset_cause_flags_r[`FLG_LOWV]
                && $stable(lowvolt_level_register_r))
      else $error("low-voltage event lost");

   AST_LVKEY: assert property (@(posedge clk) disable iff (sys_rst) // R13
      lvkey_fire && clk_en |=> dev_rst_r && reset_cause_flags_r[`FLG_LVKEY]
                               && lowvolt_level_register_r == `LVSEL_POR)
      else $error("level key fault wrong");

endmodule : wdg_top

// ---- inc/wdg_defs.svh ----
// How it works
// (R01) Guard counter advances on slow oscillator edges, not on the system clock.
// (R02) Expiry select picks overflow at 2^8,10,12,14,15,16,17,18 slow periods.
// (R03) Enable key 10101B stops the guard timer, 01010B runs it.
// (R04) Any other key value resets the device after a delay and sets its flag.
// (R05) Guard control loads 01010B key at power-on, so the timer runs.
// (R06) Guard key reset flag is set by hardware, cleared only by software.
// (R07) Counter overflow resets the device unless software clears it in time.
// (R08) Expiry in normal running gives a full reset and sets the expiry flag.
// (R09) Expiry in power-down sets both flags, resets only program counter and stack.
// (R10) Counter clears on key reset, clear instruction or halt.
// (R11) Upper five bits of the reset cause flags always read zero.
// (R12) Low supply longer than the filter time resets and sets the low-voltage flag.
// (R13) Undefined level select resets after 2~3 slow periods and sets its flag.
// (R14) Level select register loads 01100110B at power-on.
// (R15) Low-voltage reset is off while in sleep or idle.
// (R16) Power-on reset clears the program counter to zero.
// (R17) Power-on reset drives all port registers high, pins become inputs.
// (R18) Low-voltage reset flag is set by a qualified event, cleared by software.
// (R19) Level select key reset also restores the level select power-on value.
// (R20) After any clear the counter restarts from zero and counts if enabled.
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH

// ==================================================
// Register map
`define ADDR_W        4
`define OFF_GUARD     4'h0
`define OFF_LVSEL     4'h1
`define OFF_FLAGS     4'h2
`define OFF_STATUS    4'h3

// ==================================================
// Fields and power-on values
`define GUARD_POR     8'h53
`define LVSEL_POR     8'h66
`define KEY_MSB       7
`define KEY_LSB       3
`define SEL_MSB       2
`define KEY_ON        5'h0A
`define KEY_OFF       5'h15
`define FLG_GKEY      0
`define FLG_LVKEY     1
`define FLG_LOWV      2
`define FLG_W         3
`define ST_EXP        0
`define ST_PD         1
`define ST_CAUSE_LSB  2
`define ST_CAUSE_MSB  4

// ==================================================
// Level select codes
`define LV_1V7        8'h66
`define LV_1V9        8'h55
`define LV_2V55       8'h33
`define LV_3V15       8'h99
`define LV_3V8        8'hAA
`define LV_OFF        8'hF0

// ==================================================
// Counter overflow points, last count before expiry
`define CNT_W         18
`define LAST_S0       18'h000FF
`define LAST_S1       18'h003FF
`define LAST_S2       18'h00FFF
`define LAST_S3       18'h03FFF
`define LAST_S4       18'h07FFF
`define LAST_S5       18'h0FFFF
`define LAST_S6       18'h1FFFF
`define LAST_S7       18'h3FFFF

// ==================================================
// Timing
`define SLOW_OSC_HZ   32000
`define CLK_PERIOD_NS 4
`define LV_FILTER_NS  100000
`define LV_CNT_W      20
`define KEY_TICKS     2'h3
`define SYNC_W        2

`endif

// ---- inc/wdg_pkg.sv ----
// ==================================================
// Shared types
package wdg_pkg;

   typedef logic [7:0] wdg_byte_t;

   // Last reset cause, Gray steps along the usual order
   typedef enum logic [2:0] {
      CAUSE_NONE   = 3'h0,
      CAUSE_EXPIRY = 3'h1,
      CAUSE_GKEY   = 3'h3,
      CAUSE_LVKEY  = 3'h2,
      CAUSE_LOWV   = 3'h6
   } wdg_cause_t;

endpackage : wdg_pkg

// ---- logic/wdg_sync3.sv ----
`timescale 1ns/1ps
`include "wdg_defs.svh"

// ==================================================
// Three-stage pin synchroniser, level moves once stages two and three agree
module wdg_sync3 (
   // Clock and control
   input  logic clk,
   input  logic sys_rst,
   input  logic clk_en,
   // Pin and clean level
   input  logic pin,
   output logic level_r
);

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // Stage one feeds only stage two, to keep metastability contained
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_r    <= 1'h0;
         s2_r    <= 1'h0;
         s3_r    <= 1'h0;
         level_r <= 1'h0;
      end else if (clk_en) begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
      end
   end

endmodule : wdg_sync3

// ---- logic/wdg_slow_delay.sv ----
`timescale 1ns/1ps
`include "wdg_defs.svh"

// ==================================================
// Key fault delay in slow periods, fires on the third slow edge while armed
module wdg_slow_delay (
   // Clock and control
   input  logic clk,
   input  logic sys_rst,
   input  logic clk_en,
   // Arm level and slow edge
   input  logic arm,
   input  logic tick,
   output logic fire_r
);

   logic [1:0] cnt_r;

   // Third edge after arming lands 2 to 3 slow periods later, phase unknown
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r  <= 2'h0;
         fire_r <= 1'h0;
      end else if (clk_en) begin
         fire_r <= 1'h0;
         if (!arm) begin
            cnt_r <= 2'h0;
         end else if (tick) begin
            if (cnt_r == `KEY_TICKS - 2'h1) begin
               fire_r <= 1'h1;
               cnt_r  <= 2'h0;
            end else begin
               cnt_r <= cnt_r + 2'h1;
            end
         end
      end
   end

endmodule : wdg_slow_delay

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "wdg_defs.svh"

// ==================================================
// Self-checking bench for the guard timer and reset cause logic
module testbench;
   typedef struct packed {
      logic [3:0] addr;
      logic       wr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } wdg_row_t;

   logic               clk, sys_rst, reg_wr, reg_rd, clr_ins, halt_exec, pd_mode, osc, lowv;
   logic [`ADDR_W-1:0] reg_addr;
   wdg_pkg::wdg_byte_t reg_wdata, rd_data_r, got;
   logic               dev_rst_r, pcsp_rst_r, pc_clear_r, port_high_r;
   logic               expiry_flag_r, powerdown_flag_r, clk_en;
   int                 n_mismatch, tests_run, n_dev, n_pcsp;

   // Register rows: read back after an optional write
   wdg_row_t rows [14] = '{
      '{`OFF_GUARD, 1'h0, 8'h00, 8'h53}, '{`OFF_LVSEL, 1'h0, 8'h00, 8'h66},
      '{`OFF_FLAGS, 1'h0, 8'h00, 8'h00}, '{`OFF_STATUS, 1'h0, 8'h00, 8'h00},
      '{4'h7, 1'h1, 8'hFF, 8'h00}, '{`OFF_FLAGS, 1'h1, 8'hFF, 8'h00},
      '{`OFF_GUARD, 1'h1, 8'hA9, 8'hA9}, '{`OFF_GUARD, 1'h1, 8'h57, 8'h57},
      '{`OFF_LVSEL, 1'h1, 8'h55, 8'h55}, '{`OFF_LVSEL, 1'h1, 8'h33, 8'h33},
      '{`OFF_LVSEL, 1'h1, 8'h99, 8'h99}, '{`OFF_LVSEL, 1'h1, 8'hAA, 8'hAA},
      '{`OFF_LVSEL, 1'h1, 8'hF0, 8'hF0}, '{`OFF_LVSEL, 1'h1, 8'h66, 8'h66}};

   wdg_top #(.LV_FILTER_CYC(8)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .rd_data_r(rd_data_r), .clear_guard_instruction(clr_ins), .halt_exec(halt_exec),
      .pd_mode(pd_mode), .slow_internal_osc(osc), .lowvolt_det(lowv),
      .dev_rst_r(dev_rst_r), .pcsp_rst_r(pcsp_rst_r), .pc_clear_r(pc_clear_r),
      .port_high_r(port_high_r), .expiry_flag_r(expiry_flag_r),
      .powerdown_flag_r(powerdown_flag_r));

   // ==================================================
   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data lands on the edge after the strobe and stands one cycle only
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 got = rd_data_r;
   endtask : rd

   // Slow clock only moves while a test wants ticks, 13 system cycles each
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         osc <= 1'b1;
         repeat (6) @(posedge clk);
         osc <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask : ticks

   task automatic pulse(input int halt);
      @(posedge clk);
      if (halt != 0) halt_exec <= 1'b1;
      else clr_ins <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      clr_ins   <= 1'b0;
      #1;
   endtask : pulse

   task automatic lv_hold(input int n);
      @(posedge clk);
      lowv <= 1'b1;
      repeat (n) @(posedge clk);
      lowv <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : lv_hold

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Reset pulse counter; a full reset must also drive the clear outputs
   always @(posedge clk) begin
      if (!sys_rst && dev_rst_r === 1'b1) begin
         n_dev++;
         chk("reset_companions", 8'h03, {6'h00, pc_clear_r, port_high_r});
      end
      if (!sys_rst && pcsp_rst_r === 1'b1) n_pcsp++;
   end

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH run_length expected finish seen timeout");
      wrap_up();
   end

   initial begin
      {reg_wr, reg_rd, clr_ins, halt_exec, pd_mode, osc, lowv} = 7'h00;
      reg_addr = 4'h0;
      clk_en = 1'b1;
      reg_wdata = 8'h00;
      sys_rst = 1'b1;
      {n_mismatch, tests_run, n_dev, n_pcsp} = '0;
      repeat (19) @(posedge clk);
      #1 chk("reset_outputs", 8'h06, {5'h00, pc_clear_r, port_high_r, dev_rst_r});
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 chk("after_release", 8'h00, {6'h00, pc_clear_r, port_high_r});
      // Register defaults, access, unmapped place, all level codes
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr);
         chk($sformatf("row_%0d", i), rows[i].exp, got);
      end
      chk("no_reset_valid_codes", 8'h00, 8'(n_dev));
      // Clear in time, then let it overflow at 2^8
      wr(`OFF_GUARD, 8'h50);
      ticks(200);
      pulse(0);
      ticks(255);
      chk("dev_before_expiry", 8'h00, 8'(n_dev));
      ticks(1);
      chk("dev_at_expiry", 8'h01, 8'(n_dev));
      chk("flags_normal", 8'h01, {6'h00, powerdown_flag_r, expiry_flag_r});
      rd(`OFF_GUARD);
      chk("guard_reload", 8'h53, got);
      pulse(0);
      chk("flags_cleared", 8'h00, {6'h00, powerdown_flag_r, expiry_flag_r});
      // Expiry after halt while powered down
      wr(`OFF_GUARD, 8'h50);
      pulse(1);
      chk("flags_halt", 8'h02, {6'h00, powerdown_flag_r, expiry_flag_r});
      pd_mode <= 1'b1;
      ticks(256);
      chk("pcsp_pulses", 8'h01, 8'(n_pcsp));
      chk("dev_pd", 8'h01, 8'(n_dev));
      chk("flags_pd", 8'h03, {6'h00, powerdown_flag_r, expiry_flag_r});
      rd(`OFF_GUARD);
      chk("guard_kept_pd", 8'h50, got);
      pd_mode <= 1'b0;
      // Disabled timer never expires
      wr(`OFF_GUARD, 8'hA8);
      ticks(300);
      chk("dev_disabled", 8'h01, 8'(n_dev));
      chk("pcsp_disabled", 8'h01, 8'(n_pcsp));
      // Corrupt enable key
      wr(`OFF_GUARD, 8'h20);
      ticks(2);
      chk("dev_key_early", 8'h01, 8'(n_dev));
      ticks(1);
      chk("dev_key", 8'h02, 8'(n_dev));
      // Both status flags survive the key reset, cause field shows the key fault
      rd(`OFF_STATUS);
      chk("status_key", 8'h0F, got);
      rd(`OFF_FLAGS);
      chk("flag_key", 8'h01, got);
      rd(`OFF_GUARD);
      chk("guard_after_key", 8'h53, got);
      // Corrupt level select
      wr(`OFF_LVSEL, 8'h12);
      ticks(2);
      chk("dev_lv_early", 8'h02, 8'(n_dev));
      ticks(1);
      chk("dev_lv_key", 8'h03, 8'(n_dev));
      rd(`OFF_FLAGS);
      chk("flag_lv_key", 8'h03, got);
      rd(`OFF_LVSEL);
      chk("lvsel_restored", 8'h66, got);
      // Software clear: zero clears, one keeps
      wr(`OFF_FLAGS, 8'hFE);
      rd(`OFF_FLAGS);
      chk("flags_partial", 8'h02, got);
      wr(`OFF_FLAGS, 8'h00);
      rd(`OFF_FLAGS);
      chk("flags_zero", 8'h00, got);
      // Low supply: short dip, long dip, power-down, disable code
      lv_hold(4);
      chk("dev_short_dip", 8'h03, 8'(n_dev));
      // Long enough for one filter period only, a steady low would retrigger
      lv_hold(12);
      chk("dev_long_dip", 8'h04, 8'(n_dev));
      rd(`OFF_FLAGS);
      chk("flag_lowv", 8'h04, got);
      rd(`OFF_LVSEL);
      chk("lvsel_kept", 8'h66, got);
      pd_mode <= 1'b1;
      lv_hold(20);
      chk("dev_lv_pd", 8'h04, 8'(n_dev));
      pd_mode <= 1'b0;
      wr(`OFF_LVSEL, 8'hF0);
      lv_hold(20);
      chk("dev_lv_off", 8'h04, 8'(n_dev));
      // Select 001 overflows after 2^10 slow periods
      wr(`OFF_GUARD, 8'h51);
      ticks(1023);
      chk("dev_sel1_early", 8'h04, 8'(n_dev));
      ticks(1);
      chk("dev_sel1", 8'h05, 8'(n_dev));
      // Frozen enable drops a write; a mid-run reset restores power-on values
      clk_en <= 1'b0;
      wr(`OFF_GUARD, 8'hA9);
      clk_en <= 1'b1;
      rd(`OFF_GUARD);
      chk("guard_frozen", 8'h53, got);
      wr(`OFF_GUARD, 8'hA9);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`OFF_GUARD);
      chk("guard_mid_reset", 8'h53, got);
      wrap_up();
   end
endmodule : testbench
